// ---- pkg/dqts_pkg.sv ----
// Contract
// - Four 5-bit queue thresholds sit at bits 4-0, 12-8, 20-16 and 28-24 of the threshold config.
// - A queue whose valid entry count is at or above its threshold sets its error and exceeded flag.
// - Threshold 11h disables reporting for that queue, and software never writes 12h to 1Fh.
// - Every threshold field resets to 16, the full queue depth.
// - Exceeded flag holds until software writes 1 to the queue's clear bit, which also sets the watermark to the queue's current valid entry count.
// - Status bits 19-16 show, per queue, that at least one transfer request is queued there.
// - A 6-bit outstanding completion count in status bits 13-8 counts up on each reporting submit.
// - Each valid returned completion code counts a nonzero outstanding completion count down once.
// - At a count of 63 no new transfer request is taken until a completion code brings it lower.
// - Status bit 4 is the OR of all activity indicators and covers a request's whole life.
// - Status bit 2 shows that request processing and submission is active.
// - Status bit 1 shows that at least one enabled quick event is latched.
// - Status bit 0 shows that at least one enabled, manually set or chained DMA event is active.
`default_nettype none
package dqts_pkg;
  localparam int NUM_QUEUES = 4;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_THR_CFG = 8'h00;
  localparam logic [7:0] OFF_ACT_STAT = 8'h04;
  localparam logic [7:0] OFF_ERR = 8'h08;
  localparam logic [7:0] OFF_ERR_CLR = 8'h0C;
  localparam logic [7:0] OFF_QSTAT0 = 8'h10;
  localparam logic [7:0] OFF_QUEUE_STATUS_REG_STEP = 8'h04;
  // Field positions
  localparam int THR_FIELD_STRIDE = 8;
  localparam int ERR_QTHR_LSB = 16;
  localparam int QS_EXCEED_BIT = 24;
  localparam int QS_WM_LSB = 16;
  localparam int QS_VALID_ENTRY_COUNT_LSB = 8;
  localparam int ST_EVT_BIT = 0;
  localparam int ST_QEVT_BIT = 1;
  localparam int ST_SUBMIT_BIT = 2;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_COMP_LSB = 8;
  localparam int ST_QACT_LSB = 16;
  localparam int OPT_COMP_INT_BIT = 20;
  localparam int OPT_COMP_CHAIN_BIT = 22;
  // Values
  localparam logic [4:0] THR_RESET = 5'h10;
  localparam logic [4:0] THR_DISABLE = 5'h11;
  localparam logic [5:0] COMP_MAX = 6'h3F;
  localparam logic [31:0] THR_CFG_MASK = 32'h1F1F_1F1F;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;

  typedef logic [4:0] dqts_cnt_t;
  typedef logic [NUM_QUEUES-1:0][4:0] dqts_qcnt_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dqts_bus_t;

  typedef struct packed {
    logic valid;
    logic [31:0] opts;
  } dqts_tr_t;

  typedef struct packed {
    logic valid;
    logic [5:0] code;
  } dqts_tcc_t;

  typedef struct packed {
    logic [63:0] latched;
    logic [63:0] enabled;
    logic [63:0] manual;
    logic [63:0] chained;
    logic [7:0] quick;
  } dqts_evt_t;
endpackage
`default_nettype wire

// ---- rtl/dqts_top.sv ----
`default_nettype none
module dqts_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire dqts_pkg::dqts_bus_t bus,
  output logic [31:0] reg_rdata,
  // Queue manager occupancy
  input wire dqts_pkg::dqts_qcnt_t valid_entry_count,
  // Event registers
  input wire dqts_pkg::dqts_evt_t events,
  // Transfer request submission
  input wire dqts_pkg::dqts_tr_t transfer_request,
  output logic tr_ready,
  // Completion codes from transfer controllers
  input wire dqts_pkg::dqts_tcc_t transfer_completion_code,
  // Error and activity outputs
  output logic [3:0] queue_threshold_error_bit,
  output logic controller_busy_flag
);

  typedef struct packed {
    logic [31:0] thr_cfg;
    logic [3:0] exceeded;
    logic [3:0][4:0] watermark;
    logic [5:0] comp_count;
    logic [31:0] rdata;
  } dqts_state_t;

  dqts_state_t state_reg;
  dqts_state_t state_next;

  function automatic logic [4:0] thr_of(input logic [31:0] cfg, input int q);
    thr_of = cfg[q*dqts_pkg::THR_FIELD_STRIDE +: 5];
  endfunction

  logic [3:0] queue_nonempty_flag;
  logic [3:0] over_thr;
  logic quick_event_active;
  logic dma_event_active;
  logic request_submit_active;
  logic reporting;
  logic submit;
  logic inc;
  logic dec;
  logic [31:0] status_word;
  logic [31:0] err_word;
  logic [3:0] clr;

  always_comb begin
    for (int q = 0; q < dqts_pkg::NUM_QUEUES; q++) begin
      queue_nonempty_flag[q] = (valid_entry_count[q] != 5'h00);
      // Thresholds above 11h are reserved; count never reaches them, so they also stay quiet
      over_thr[q] = (thr_of(state_reg.thr_cfg, q) != dqts_pkg::THR_DISABLE) &&
                    (valid_entry_count[q] >= thr_of(state_reg.thr_cfg, q));
    end
  end

  assign quick_event_active = |events.quick;
  assign dma_event_active = |((events.latched & events.enabled) | events.manual |
                              events.chained);
  assign request_submit_active = transfer_request.valid;

  // Stall at 63 so the counter can never wrap and lose a pending completion
  assign tr_ready = (state_reg.comp_count != dqts_pkg::COMP_MAX);
  assign submit = transfer_request.valid && tr_ready;
  assign reporting = transfer_request.opts[dqts_pkg::OPT_COMP_INT_BIT] ||
                     transfer_request.opts[dqts_pkg::OPT_COMP_CHAIN_BIT];
  assign inc = submit && reporting;
  // A code with nothing outstanding is dropped rather than wrapping to 63
  assign dec = transfer_completion_code.valid && (state_reg.comp_count != 6'h00);

  assign controller_busy_flag = (|queue_nonempty_flag) || request_submit_active ||
                                quick_event_active || dma_event_active ||
                                (state_reg.comp_count != 6'h00);

  always_comb begin
    status_word = dqts_pkg::STAT_RESET;
    status_word[dqts_pkg::ST_QACT_LSB +: 4] = queue_nonempty_flag;
    status_word[dqts_pkg::ST_COMP_LSB +: 6] = state_reg.comp_count;
    status_word[dqts_pkg::ST_BUSY_BIT] = controller_busy_flag;
    status_word[dqts_pkg::ST_SUBMIT_BIT] = request_submit_active;
    status_word[dqts_pkg::ST_QEVT_BIT] = quick_event_active;
    status_word[dqts_pkg::ST_EVT_BIT] = dma_event_active;
    err_word = 32'h0000_0000;
    err_word[dqts_pkg::ERR_QTHR_LSB +: 4] = state_reg.exceeded;
  end

  assign clr = (bus.wr && bus.addr == dqts_pkg::OFF_ERR_CLR) ?
               bus.wdata[dqts_pkg::ERR_QTHR_LSB +: 4] : 4'h0;

  always_comb begin
    state_next = state_reg;
    if (bus.wr && bus.addr == dqts_pkg::OFF_THR_CFG) begin
      // Reserved bits are held at zero whatever software writes
      state_next.thr_cfg = bus.wdata & dqts_pkg::THR_CFG_MASK;
    end
    // Writes to the activity status offset fall through with no effect
    for (int q = 0; q < dqts_pkg::NUM_QUEUES; q++) begin
      // Set wins over clear so an overrun in the clear cycle is not lost
      state_next.exceeded[q] = over_thr[q] || (state_reg.exceeded[q] && !clr[q]);
      if (clr[q]) begin
        state_next.watermark[q] = valid_entry_count[q];
      end else if (valid_entry_count[q] > state_reg.watermark[q]) begin
        state_next.watermark[q] = valid_entry_count[q];
      end
    end
    if (inc && !dec) begin
      state_next.comp_count = state_reg.comp_count + 6'h01;
    end else if (dec && !inc) begin
      state_next.comp_count = state_reg.comp_count - 6'h01;
    end
    state_next.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        dqts_pkg::OFF_THR_CFG: begin
          state_next.rdata = state_reg.thr_cfg;
        end
        dqts_pkg::OFF_ACT_STAT: begin
          state_next.rdata = status_word;
        end
        dqts_pkg::OFF_ERR: begin
          state_next.rdata = err_word;
        end
        default: begin
          for (int q = 0; q < dqts_pkg::NUM_QUEUES; q++) begin
            if (bus.addr == dqts_pkg::OFF_QSTAT0 + 8'(q) * dqts_pkg::OFF_QUEUE_STATUS_REG_STEP) begin
              state_next.rdata[dqts_pkg::QS_EXCEED_BIT] = state_reg.exceeded[q];
              state_next.rdata[dqts_pkg::QS_WM_LSB +: 5] = state_reg.watermark[q];
              state_next.rdata[dqts_pkg::QS_VALID_ENTRY_COUNT_LSB +: 5] = valid_entry_count[q];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg.thr_cfg <= {3'b000, dqts_pkg::THR_RESET, 3'b000, dqts_pkg::THR_RESET,
                            3'b000, dqts_pkg::THR_RESET, 3'b000, dqts_pkg::THR_RESET};
      state_reg.exceeded <= 4'h0;
      state_reg.watermark <= '0;
      state_reg.comp_count <= 6'h00;
      state_reg.rdata <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign queue_threshold_error_bit = state_reg.exceeded;

endmodule // dqts_top
`default_nettype wire

// ---- test/dqts_props.sv ----
`default_nettype none
module dqts_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Watched ports
  input wire dqts_pkg::dqts_bus_t bus,
  input wire logic [31:0] reg_rdata,
  input wire dqts_pkg::dqts_qcnt_t valid_entry_count,
  input wire dqts_pkg::dqts_evt_t events,
  input wire dqts_pkg::dqts_tr_t transfer_request,
  input wire logic tr_ready,
  input wire logic [3:0] queue_threshold_error_bit,
  input wire logic controller_busy_flag
);
  logic st_rd;
  logic clr_wr;
  logic [3:0] q_ne;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  assign st_rd = bus.rd && bus.addr == dqts_pkg::OFF_ACT_STAT;
  assign clr_wr = bus.wr && bus.addr == dqts_pkg::OFF_ERR_CLR;
  always_comb begin
    for (int q = 0; q < 4; q++) q_ne[q] = valid_entry_count[q] != '0;
  end
  a_stat_rsvd: assert property (st_rd |=> {reg_rdata[31:20], reg_rdata[15:14]} == '0)
    else $error("status reserved bits not zero");
  a_err_sticky: assert property (!clr_wr |=>
    (queue_threshold_error_bit & $past(queue_threshold_error_bit)) == $past(queue_threshold_error_bit))
    else $error("error flag dropped without clear");
  a_submit_rd: assert property (st_rd |=> reg_rdata[2] == $past(transfer_request.valid))
    else $error("submit active bit wrong");
  a_qevt_rd: assert property (st_rd |=> reg_rdata[1] == $past(|events.quick))
    else $error("quick event bit wrong");
  a_qact_rd: assert property (st_rd |=> reg_rdata[19:16] == $past(q_ne))
    else $error("queue nonempty bits wrong");
  a_full_rd: assert property (st_rd && !tr_ready |=> reg_rdata[13:8] == 6'h3F)
    else $error("requests stalled below full count");
  a_cfg_rsvd: assert property (bus.rd && bus.addr == '0 |=>
    (reg_rdata & ~dqts_pkg::THR_CFG_MASK) == '0) else $error("threshold reserved bits set");
  a_busy_src: assert property (transfer_request.valid || |events.quick || |q_ne
    |-> controller_busy_flag) else $error("busy flag low while active");
  cover property (!tr_ready);
  cover property (|queue_threshold_error_bit);
  cover property (st_rd ##1 reg_rdata[4]);
endmodule // dqts_props
bind dqts_top dqts_props i_props (.*);
`default_nettype wire

// ---- test/dqts_tc_model.sv ----
`default_nettype none
module dqts_tc_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Request side
  input wire dqts_pkg::dqts_tr_t transfer_request,
  input wire logic tr_ready,
  input wire logic stall,
  // Completion return
  output var dqts_pkg::dqts_tcc_t transfer_completion_code
);
  logic [6:0] pend_reg;
  logic take;
  logic ret;
  // Only reporting requests earn a code back; stall lets the count pile up
  assign take = transfer_request.valid && tr_ready && (transfer_request.opts[20] ||
    transfer_request.opts[22]);
  assign ret = !stall && pend_reg != '0;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= '0;
      transfer_completion_code <= '0;
    end else begin
      transfer_completion_code <= '{valid: ret, code: pend_reg[5:0]};
      pend_reg <= pend_reg + 7'(take) - 7'(ret);
    end
  end
endmodule // dqts_tc_model
`default_nettype wire

// ---- test/dqts_bench.sv ----
`default_nettype none
module dqts_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0;
  logic rstn = 0;
  logic stall = 1;
  logic tr_ready;
  logic controller_busy_flag;
  logic [31:0] reg_rdata;
  logic [3:0] queue_threshold_error_bit;
  int n_errors = 0;
  int check_count = 0;
  dqts_pkg::dqts_bus_t bus = '0;
  dqts_pkg::dqts_qcnt_t valid_entry_count = '0;
  dqts_pkg::dqts_evt_t events = '0;
  dqts_pkg::dqts_tr_t transfer_request = '0;
  dqts_pkg::dqts_tcc_t transfer_completion_code;
  dqts_top i_dut (.*);
  dqts_tc_model i_tc (.*);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic sub(logic [31:0] o);
    @(posedge core_clk);
    transfer_request <= '{valid: 1'b1, opts: o};
    do @(posedge core_clk); while (!tr_ready);
    transfer_request.valid <= 1'b0;
  endtask
  task automatic t_regs();
    rd(8'h00, 32'h1010_1010);
    wr(8'h04, 32'h0000_0010);
    rd(8'h04, 32'h0000_0000);
    rd(8'hF0, 32'h0000_0000);
    wr(8'h00, 32'h0011_0203);
    rd(8'h00, 32'h0011_0203);
  endtask
  task automatic t_thr();
    @(posedge core_clk);
    valid_entry_count <= '{5'h00, 5'h10, 5'h01, 5'h03};
    repeat (2) @(posedge core_clk);
    #1 chk("error bits", 32'h0000_0009, 32'(queue_threshold_error_bit));
    rd(8'h08, 32'h0009_0000);
    rd(8'h10, 32'h0103_0300);
    @(posedge core_clk);
    valid_entry_count[0] <= '0;
    events.quick <= 8'h01;
    events.latched[5] <= 1'b1;
    events.enabled[5] <= 1'b1;
    rd(8'h04, 32'h0006_0013);
    chk("error bits", 32'h0000_0009, 32'(queue_threshold_error_bit));
    wr(8'h0C, 32'h000F_0000);
    @(posedge core_clk);
    #1 chk("error bits", 32'h0000_0008, 32'(queue_threshold_error_bit));
    rd(8'h10, 32'h0000_0000);
    @(posedge core_clk);
    events <= '0;
    valid_entry_count <= '0;
  endtask
  task automatic t_comp();
    sub(32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    for (int i = 0; i < 63; i++) sub(i[0] ? 32'h0040_0000 : 32'h0010_0000);
    @(posedge core_clk);
    transfer_request <= '{valid: 1'b1, opts: 32'h0010_0000};
    repeat (3) @(posedge core_clk);
    #1 chk("ready", 32'h0000_0000, 32'(tr_ready));
    rd(8'h04, 32'h0000_3F14);
    @(posedge core_clk);
    stall <= 1'b0;
    do @(posedge core_clk); while (!tr_ready);
    transfer_request.valid <= 1'b0;
    for (int i = 0; i < 200 && controller_busy_flag !== 1'b0; i++) @(posedge core_clk);
    rd(8'h04, 32'h0000_0000);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_thr();
    t_comp();
    print_verdict();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #50000;
    n_errors++;
    print_verdict();
  end
endmodule // dqts_bench
`default_nettype wire
